// ### core/dip_seq.v
// Overview of operation
// - a dwell waits for zero remaining distance, then holds its time.
// - an input-wait step holds advance until the chosen input turns on.
// - interrupt positioning moves the set distance from the input origin.
// - interrupt is skipped if its distance is below the prior move travel.
// - interrupt is skipped if remaining distance is at or below its value.
// - interrupt is skipped if the motor is decelerating at that moment.
// - a short interrupt distance forces a shortened deceleration time.
// - the stop point follows the speed when the interrupt becomes active.
`timescale 1ns/1ns
`include "dip_map.vh"
module dip_seq #(
	parameter DW = 32,
	parameter TW = 16,
	parameter MS_CYC = `DIP_MS_CYC
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire step_valid_i,
	input wire [`DIP_CMD_W-1:0] step_cmd_i,
	input wire [DW-1:0] step_value_i,
	input wire [1:0] step_input_sel_i,
	input wire [2:0] prog_input_i,
	input wire [DW-1:0] remain_dist_i,
	input wire [DW-1:0] decel_dist_i,
	input wire [DW-1:0] last_travel_i,
	input wire decelerating_i,
	output reg step_advance_o,
	output reg intr_start_o,
	output reg [DW-1:0] intr_dist_o,
	output reg short_decel_o,
	output reg intr_skip_o,
	output reg busy_o
);
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [TW-1:0] ms_left_q;
	reg [TW-1:0] ms_left_d;
	reg [DW-1:0] val_q;
	reg [DW-1:0] val_d;
	reg [1:0] sel_q;
	reg [1:0] sel_d;
	reg adv_d;
	reg start_d;
	reg [DW-1:0] dist_d;
	reg short_d;
	reg skip_d;
	reg busy_d;
	wire ms_tick;
	wire in_on;
	wire dw_run;
	wire [3:0] sel_hot;
	wire [2:0] in_hit;
	wire dist_zero;
	wire ms_zero;
	wire ms_last;
	wire skip_travel;
	wire skip_near;
	wire skip_decel;
	wire intr_skip;
	wire need_short;

	// select code 3 lights no input, so such a wait never releases
	assign sel_hot = 4'h1 << sel_q;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_in
			assign in_hit[gi] = prog_input_i[gi] & sel_hot[gi];
		end
	endgenerate

	assign in_on = |in_hit;
	assign dw_run = (state_q == `DIP_ST_DW_TIME);
	assign dist_zero = (remain_dist_i == {DW{1'b0}});
	assign ms_zero = (ms_left_q == {TW{1'b0}});
	assign ms_last = (ms_left_q == {{(TW-1){1'b0}}, 1'b1});

	// skip tests use the values that stand at the check cycle
	assign skip_travel = (val_q < last_travel_i);
	assign skip_near = (remain_dist_i <= val_q);
	assign skip_decel = decelerating_i;
	assign intr_skip = skip_travel | skip_near | skip_decel;
	// the generator shortens its ramp; we only flag the need
	assign need_short = (val_q < decel_dist_i);

	// timer restarts on each dwell so every millisecond is whole
	dip_ms_tick #(
		.CYC(MS_CYC)
	) u_tick (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.run_i(dw_run),
		.tick_o(ms_tick)
	);

	always @* begin
		state_d = state_q;
		ms_left_d = ms_left_q;
		val_d = val_q;
		sel_d = sel_q;
		adv_d = 1'b0;
		start_d = 1'b0;
		dist_d = intr_dist_o;
		short_d = short_decel_o;
		skip_d = 1'b0;
		busy_d = busy_o;
		case (state_q)
		`DIP_ST_IDLE: begin
			busy_d = 1'b0;
			if (step_valid_i) begin
				busy_d = 1'b1;
				val_d = step_value_i;
				sel_d = step_input_sel_i;
				ms_left_d = step_value_i[TW-1:0];
				case (step_cmd_i)
				`DIP_CMD_DWELL: begin
					state_d = `DIP_ST_DW_WAIT;
				end
				`DIP_CMD_SYNC: begin
					state_d = `DIP_ST_SYNC;
				end
				`DIP_CMD_INTR: begin
					state_d = `DIP_ST_INTR_CHK;
				end
				default: begin
					state_d = `DIP_ST_ADV;
				end
				endcase
			end
		end
		`DIP_ST_DW_WAIT: begin
			// a dwell at program start sees zero and only delays
			if (dist_zero) begin
				if (ms_zero) begin
					state_d = `DIP_ST_ADV;
				end else begin
					state_d = `DIP_ST_DW_TIME;
				end
			end
		end
		`DIP_ST_DW_TIME: begin
			if (ms_tick) begin
				if (ms_last) begin
					state_d = `DIP_ST_ADV;
				end
				ms_left_d = ms_left_q - 1'b1;
			end
		end
		`DIP_ST_SYNC: begin
			// a level input; an input already on releases at once
			if (in_on) begin
				state_d = `DIP_ST_ADV;
			end
		end
		`DIP_ST_INTR_CHK: begin
			// origin is the instant this step starts, right after the
			// preceding input-wait released, so speed sets the stop
			if (intr_skip) begin
				skip_d = 1'b1;
				state_d = `DIP_ST_ADV;
			end else begin
				start_d = 1'b1;
				dist_d = val_q;
				short_d = need_short;
				state_d = `DIP_ST_INTR_RUN;
			end
		end
		`DIP_ST_INTR_RUN: begin
			if (dist_zero) begin
				short_d = 1'b0;
				state_d = `DIP_ST_ADV;
			end
		end
		`DIP_ST_ADV: begin
			adv_d = 1'b1;
			busy_d = 1'b0;
			state_d = `DIP_ST_IDLE;
		end
		default: begin
			state_d = `DIP_ST_IDLE;
		end
		endcase
	end

	// every output is a flip-flop so the far side sees clean levels
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= `DIP_ST_IDLE;
			ms_left_q <= {TW{1'b0}};
			val_q <= {DW{1'b0}};
			sel_q <= 2'h0;
			step_advance_o <= 1'b0;
			intr_start_o <= 1'b0;
			intr_dist_o <= {DW{1'b0}};
			short_decel_o <= 1'b0;
			intr_skip_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			state_q <= state_d;
			ms_left_q <= ms_left_d;
			val_q <= val_d;
			sel_q <= sel_d;
			step_advance_o <= adv_d;
			intr_start_o <= start_d;
			intr_dist_o <= dist_d;
			short_decel_o <= short_d;
			intr_skip_o <= skip_d;
			busy_o <= busy_d;
		end
	end
endmodule

// ### core/dip_map.vh
`ifndef DIP_MAP_VH
`define DIP_MAP_VH
// step command codes presented by the program store
`define DIP_CMD_W 3
`define DIP_CMD_NOP 3'h0
`define DIP_CMD_DWELL 3'h1
`define DIP_CMD_SYNC 3'h2
`define DIP_CMD_INTR 3'h3
`define DIP_CMD_MOVE 3'h4
// timing: one millisecond at 20 MHz
`define DIP_CLK_HZ 20000000
`define DIP_MS_CYC (`DIP_CLK_HZ / 1000)
`define DIP_MS_CW 15
// sequencer states
`define DIP_ST_IDLE 3'h0
`define DIP_ST_DW_WAIT 3'h1
`define DIP_ST_DW_TIME 3'h2
`define DIP_ST_SYNC 3'h3
`define DIP_ST_INTR_CHK 3'h4
`define DIP_ST_INTR_RUN 3'h5
`define DIP_ST_ADV 3'h6
`endif

// ### core/dip_ms_tick.v
`timescale 1ns/1ns
`include "dip_map.vh"
module dip_ms_tick #(
	parameter CYC = `DIP_MS_CYC
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire run_i,
	output reg tick_o
);
	localparam [31:0] LAST = CYC - 1;
	reg [`DIP_MS_CW-1:0] cnt_q;
	wire [31:0] cnt_w;

	// compare at full width so no bit of the period is lost
	assign cnt_w = {{(32-`DIP_MS_CW){1'b0}}, cnt_q};
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= {`DIP_MS_CW{1'b0}};
			tick_o <= 1'b0;
		end else if (!run_i) begin
			cnt_q <= {`DIP_MS_CW{1'b0}};
			tick_o <= 1'b0;
		end else if (cnt_w == LAST) begin
			cnt_q <= {`DIP_MS_CW{1'b0}};
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick_o <= 1'b0;
		end
	end
endmodule

// ### dv/dip_motion.sv
`timescale 1ns/1ns
module dip_motion (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire ld_i,
	input wire [31:0] ld_val_i,
	output reg [31:0] remain_o
);
	// distance counts from the load cycle, so origin is the start cycle
	always @(posedge sys_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			remain_o <= 32'h0;
		else if (ld_i)
			remain_o <= ld_val_i;
		else if (remain_o != 32'h0)
			remain_o <= remain_o - 32'h1;
endmodule

// ### dv/dip_seq_properties.sv
`timescale 1ns/1ns
module dip_seq_properties (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire step_valid_i,
	input wire [2:0] step_cmd_i,
	input wire [31:0] step_value_i,
	input wire [31:0] remain_dist_i,
	input wire [31:0] decel_dist_i,
	input wire [31:0] last_travel_i,
	input wire decelerating_i,
	input wire step_advance_o,
	input wire intr_start_o,
	input wire [31:0] intr_dist_o,
	input wire short_decel_o,
	input wire intr_skip_o,
	input wire busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire tk = !busy_o && step_valid_i && step_cmd_i == 3'h3;
	wire sk = decelerating_i || remain_dist_i <= step_value_i ||
		step_value_i < last_travel_i;
	AST_SKIP: assert property (tk ##1 sk |=> intr_skip_o)
		else $error("skip missing");
	AST_GO: assert property (tk ##1 !sk |=> intr_start_o)
		else $error("start missing");
	AST_DIST: assert property (intr_start_o |-> intr_dist_o == step_value_i)
		else $error("wrong distance");
	AST_SKIP_ADV: assert property (intr_skip_o |=> step_advance_o)
		else $error("no advance after skip");
	AST_EXCL: assert property (!(intr_skip_o && intr_start_o))
		else $error("start and skip together");
	AST_SHORT_END: assert property (step_advance_o |-> !short_decel_o)
		else $error("short decel left on");
	AST_SHORT: assert property (tk ##1 !sk && decel_dist_i > step_value_i
		|-> ##[1:2] short_decel_o)
		else $error("no short decel");
	AST_ONE: assert property (step_advance_o |-> !busy_o ##1 !step_advance_o)
		else $error("advance not a pulse");
	cover property (intr_skip_o);
	cover property (intr_start_o);
	cover property (short_decel_o);
endmodule
bind dip_seq dip_seq_properties u_prop (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.step_valid_i(step_valid_i),
	.step_cmd_i(step_cmd_i),
	.step_value_i(step_value_i),
	.remain_dist_i(remain_dist_i),
	.decel_dist_i(decel_dist_i),
	.last_travel_i(last_travel_i),
	.decelerating_i(decelerating_i),
	.step_advance_o(step_advance_o),
	.intr_start_o(intr_start_o),
	.intr_dist_o(intr_dist_o),
	.short_decel_o(short_decel_o),
	.intr_skip_o(intr_skip_o),
	.busy_o(busy_o)
);

// ### dv/test_dip_seq.sv
`timescale 1ns/1ns
module test_dip_seq;
	reg sys_clk_i = 0, rst_n_i = 0, step_valid_i = 0, decelerating_i = 0;
	localparam int MS = 4;
	localparam int LIM = 400;
	reg ld = 0, s, st, sd;
	reg [2:0] step_cmd_i = 0, prog_input_i = 0;
	reg [1:0] step_input_sel_i = 0;
	reg [31:0] step_value_i = 0, decel_dist_i = 0, last_travel_i = 0, lv = 0;
	reg [31:0] rem1 = 0, d = 0;
	wire [31:0] remain_dist_i, intr_dist_o;
	wire step_advance_o, intr_start_o, short_decel_o, intr_skip_o, busy_o;
	integer bad_count = 0, n_tests = 0, c, n, i, q;
	int exp_q[$];
	always #25 sys_clk_i = ~sys_clk_i;
	dip_motion m (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ld_i(ld |
		intr_start_o), .ld_val_i(intr_start_o ? intr_dist_o : lv),
		.remain_o(remain_dist_i));
	// short millisecond keeps dwell runs brief
	dip_seq #(.MS_CYC(MS)) dut (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.step_valid_i(step_valid_i),
		.step_cmd_i(step_cmd_i),
		.step_value_i(step_value_i),
		.step_input_sel_i(step_input_sel_i),
		.prog_input_i(prog_input_i),
		.remain_dist_i(remain_dist_i),
		.decel_dist_i(decel_dist_i),
		.last_travel_i(last_travel_i),
		.decelerating_i(decelerating_i),
		.step_advance_o(step_advance_o),
		.intr_start_o(intr_start_o),
		.intr_dist_o(intr_dist_o),
		.short_decel_o(short_decel_o),
		.intr_skip_o(intr_skip_o),
		.busy_o(busy_o)
	);
	task chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t result differs", $time);
		end
	endtask
	task tally_and_finish;
		$display("tests %0d bad %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// tasks start and end on a rising edge; outputs are read mid-cycle
	task load(input [31:0] x);
		lv <= x;
		ld <= 1'b1;
		@(posedge sys_clk_i);
		ld <= 1'b0;
	endtask
	task run(input [2:0] k, input [31:0] v);
		step_cmd_i <= k;
		step_value_i <= v;
		step_valid_i <= 1'b1;
		@(posedge sys_clk_i);
		step_valid_i <= 1'b0;
		c = 0;
		s = 0;
		st = 0;
		sd = 0;
		while (step_advance_o !== 1'b1 && c < LIM) begin
			@(negedge sys_clk_i);
			c++;
			if (c == 1)
				rem1 = remain_dist_i;
			s = s | intr_skip_o;
			sd = sd | short_decel_o;
			if (intr_start_o === 1'b1) begin
				st = 1'b1;
				d = intr_dist_o;
			end
		end
		$display("step %0d done in %0d", k, c);
		if (c == LIM) begin
			chk(0, 1);
			tally_and_finish;
		end
		@(posedge sys_clk_i);
	endtask
	initial begin
		void'($urandom(32'h1186));
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		run(3'h0, 0);
		chk(c == 2, 1);
		n = $urandom % 3 + 1;
		run(3'h1, n);
		chk(c >= MS * n && c <= MS * n + 4, 1);
		n = $urandom % 16 + 5;
		load(n);
		run(3'h1, 1);
		chk(c >= n + MS && c <= n + MS + 4, 1);
		q = $urandom % 3;
		step_input_sel_i <= q[1:0];
		n = $urandom % 20 + 4;
		fork
			run(3'h2, 0);
			begin
				repeat (2) @(posedge sys_clk_i);
				prog_input_i <= ~(3'h1 << q);
				repeat (n - 2) @(posedge sys_clk_i);
				prog_input_i <= 3'h7;
			end
		join
		chk(c >= n + 1 && c <= n + 3, 1);
		for (i = 0; i < 4; i++) begin
			decelerating_i <= i == 0;
			last_travel_i <= i == 2 ? 32'h40 : 32'h0;
			decel_dist_i <= 32'h30;
			load(i == 1 ? 32'hA : 32'h64);
			run(3'h2, 0);
			run(3'h3, 32'h14);
			exp_q.push_back(32'h14 < last_travel_i || rem1 <= 32'h14 ||
				decelerating_i);
			chk(s, exp_q.pop_front());
			chk(st, !s);
		end
		chk(c >= 32'h14 && c <= 32'h14 + 6, 1);
		chk(d == 32'h14, 1);
		chk(sd, 1);
		tally_and_finish;
	end
endmodule
